// >>> hw/rlo_regs_top.sv
// apb register slice for the right line-output mixer, level, mute and power status
// assumes status inputs are synchronous to CLK and held as live levels by the analog side
//
// Overview of operation
// - left dac path route enable bit 7, volume bits 6..0, reset zero
// - right line input two route enable bit 7, volume bits 6..0, reset zero
// - right input gain stage route bit 7, volume bits 6..0, reset zero
// - right dac path route enable bit 7, volume bits 6..0, reset zero
// - level field bits 7..4, reset 0000, codes 0..9 give 0..9 dB
// - bit 3 is mute control, 0 mutes, 1 plays
// - level register bit 2 reserved, reads 0, writes ignored
// - bit 1 reads 1 from reset while programmed gains still pending
// - bit 0 reads 1 only when right line output fully powered
// - power status bit 7 left dac, bit 6 right dac powered
// - power status bit 5 reserved, reads zero
// - power status bit 4 shows left line output driver powered
// - power status bit 3 shows right line output fully powered
// - bits 2 and 1 show left and right headphone drivers powered
// - power status bit 0 reserved, reads zero
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rlo_regs_top
	import rlo_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [RLO_ADDR_W-1:0] PADDR,
	input wire logic [RLO_DATA_W-1:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [RLO_DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire rlo_power_s POWER_STATUS,
	input wire logic GAIN_APPLIED,
	output rlo_mix_s MIX_LEFT_DAC_PATH,
	output rlo_mix_s MIX_RIGHT_LINE_INPUT_TWO,
	output rlo_mix_s MIX_RIGHT_INPUT_GAIN_STAGE,
	output rlo_mix_s MIX_RIGHT_DAC_PATH,
	output rlo_out_ctrl_s RIGHT_LINE_OUTPUT_CTRL,
	output logic GAIN_UPDATE
);

	rlo_apb_e state;
	rlo_apb_e next_state;

	logic setup_phase;
	logic access_done;
	logic addr_aligned;
	logic [7:0] reg_index;
	logic sel_left_dac;
	logic sel_line_two;
	logic sel_gain_stage;
	logic sel_right_dac;
	logic sel_level_ctrl;
	logic sel_power_stat;
	logic addr_mapped;
	logic wr_commit;
	logic lane0_wr;
	logic [7:0] wr_byte;
	logic wr_left_dac;
	logic wr_line_two;
	logic wr_gain_stage;
	logic wr_right_dac;
	logic wr_level_ctrl;
	logic gain_write;
	logic gain_pending;
	logic [7:0] next_level_byte;
	logic [7:0] next_power_byte;
	logic [7:0] read_byte;
	rlo_power_s power_q;
	rlo_out_ctrl_s out_ctrl;

	// address decode, only aligned words inside the slice are mapped
	assign addr_aligned = (PADDR[1:0] == RLO_WORD_ALIGN);
	assign reg_index = PADDR[RLO_ADDR_W-1:2];
	assign sel_left_dac = addr_aligned && (reg_index == RLO_IDX_LEFT_DAC);
	assign sel_line_two = addr_aligned && (reg_index == RLO_IDX_LINE_TWO);
	assign sel_gain_stage = addr_aligned && (reg_index == RLO_IDX_GAIN_STAGE);
	assign sel_right_dac = addr_aligned && (reg_index == RLO_IDX_RIGHT_DAC);
	assign sel_level_ctrl = addr_aligned && (reg_index == RLO_IDX_LEVEL_CTRL);
	assign sel_power_stat = addr_aligned && (reg_index == RLO_IDX_POWER_STAT);
	assign addr_mapped = sel_left_dac || sel_line_two || sel_gain_stage
		|| sel_right_dac || sel_level_ctrl || sel_power_stat;

	// apb phase tracking
	assign setup_phase = PSEL && !PENABLE && (state == RLO_IDLE);
	assign access_done = PSEL && PENABLE && PREADY;

	always_comb begin
		next_state = state;
		unique case (state)
			RLO_IDLE: begin
				if (setup_phase) begin
					next_state = RLO_ACCESS;
				end
			end
			RLO_ACCESS: begin
				if (access_done) begin
					next_state = RLO_IDLE;
				end
			end
			default: begin
				next_state = RLO_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state <= RLO_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ready rises for the access phase only, so every transfer takes two cycles
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
		end else if (setup_phase) begin
			PREADY <= 1'b1;
		end else if (access_done) begin
			PREADY <= 1'b0;
		end
	end

	// unmapped or misaligned addresses answer with an error and have no effect
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PSLVERR <= 1'b0;
		end else if (setup_phase) begin
			PSLVERR <= !addr_mapped;
		end else if (access_done) begin
			PSLVERR <= 1'b0;
		end
	end

	// a write lands only at the completing edge and only through byte lane zero
	assign wr_commit = access_done && PWRITE && !PSLVERR;
	assign lane0_wr = wr_commit && PSTRB[0];
	assign wr_byte = PWDATA[RLO_REG_W-1:0];
	assign wr_left_dac = lane0_wr && sel_left_dac;
	assign wr_line_two = lane0_wr && sel_line_two;
	assign wr_gain_stage = lane0_wr && sel_gain_stage;
	assign wr_right_dac = lane0_wr && sel_right_dac;
	assign wr_level_ctrl = lane0_wr && sel_level_ctrl;
	assign gain_write = wr_left_dac || wr_line_two || wr_gain_stage
		|| wr_right_dac || wr_level_ctrl;

	rlo_mix_input_reg u_left_dac_path (
		.clk(CLK),
		.rst_n(RST_N),
		.wr_en(wr_left_dac),
		.wr_byte(wr_byte),
		.q(MIX_LEFT_DAC_PATH)
	);

	rlo_mix_input_reg u_right_line_input_two (
		.clk(CLK),
		.rst_n(RST_N),
		.wr_en(wr_line_two),
		.wr_byte(wr_byte),
		.q(MIX_RIGHT_LINE_INPUT_TWO)
	);

	rlo_mix_input_reg u_right_input_gain_stage (
		.clk(CLK),
		.rst_n(RST_N),
		.wr_en(wr_gain_stage),
		.wr_byte(wr_byte),
		.q(MIX_RIGHT_INPUT_GAIN_STAGE)
	);

	rlo_mix_input_reg u_right_dac_path (
		.clk(CLK),
		.rst_n(RST_N),
		.wr_en(wr_right_dac),
		.wr_byte(wr_byte),
		.q(MIX_RIGHT_DAC_PATH)
	);

	// level and mute; codes above nine are stored as written, the analog side decides
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			out_ctrl.level <= RLO_LEVEL_RST;
			out_ctrl.unmute <= RLO_UNMUTE_RST;
		end else if (wr_level_ctrl) begin
			out_ctrl.level <= wr_byte[RLO_LEVEL_MSB:RLO_LEVEL_LSB];
			out_ctrl.unmute <= wr_byte[RLO_UNMUTE_BIT];
		end
	end

	assign RIGHT_LINE_OUTPUT_CTRL = out_ctrl;

	// pending gains: set by any gain write, cleared by the analog side's applied pulse
	// set wins, so a write in the same cycle as the pulse stays pending
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			gain_pending <= RLO_PENDING_RST;
		end else if (gain_write) begin
			gain_pending <= 1'b1;
		end else if (GAIN_APPLIED) begin
			gain_pending <= 1'b0;
		end
	end

	// tells the analog side new gain targets exist, one cycle after the write
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			GAIN_UPDATE <= 1'b0;
		end else begin
			GAIN_UPDATE <= gain_write;
		end
	end

	// live power status, sampled every cycle so reads show state at most two cycles old
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			power_q <= '0;
		end else begin
			power_q <= POWER_STATUS;
		end
	end

	// read images; reserved bits are constants so writes cannot reach them
	always_comb begin
		next_level_byte = RLO_ZERO_BYTE;
		next_level_byte[RLO_LEVEL_MSB:RLO_LEVEL_LSB] = out_ctrl.level;
		next_level_byte[RLO_UNMUTE_BIT] = out_ctrl.unmute;
		next_level_byte[RLO_LVL_RSV_BIT] = RLO_RSV_VALUE;
		next_level_byte[RLO_PENDING_BIT] = gain_pending;
		next_level_byte[RLO_LINE_PWR_BIT] = power_q.right_line_output;
	end

	always_comb begin
		next_power_byte = RLO_ZERO_BYTE;
		next_power_byte[RLO_PS_LEFT_DAC_BIT] = power_q.left_dac;
		next_power_byte[RLO_PS_RIGHT_DAC_BIT] = power_q.right_dac;
		next_power_byte[RLO_PS_RSV_HI_BIT] = RLO_RSV_VALUE;
		next_power_byte[RLO_PS_LEFT_LINE_BIT] = power_q.left_line_output;
		next_power_byte[RLO_PS_RIGHT_LINE_BIT] = power_q.right_line_output;
		next_power_byte[RLO_PS_LEFT_HP_BIT] = power_q.left_headphone_driver;
		next_power_byte[RLO_PS_RIGHT_HP_BIT] = power_q.right_headphone_driver;
		next_power_byte[RLO_PS_RSV_LO_BIT] = RLO_RSV_VALUE;
	end

	always_comb begin
		read_byte = RLO_ZERO_BYTE;
		if (sel_left_dac) begin
			read_byte = MIX_LEFT_DAC_PATH;
		end else if (sel_line_two) begin
			read_byte = MIX_RIGHT_LINE_INPUT_TWO;
		end else if (sel_gain_stage) begin
			read_byte = MIX_RIGHT_INPUT_GAIN_STAGE;
		end else if (sel_right_dac) begin
			read_byte = MIX_RIGHT_DAC_PATH;
		end else if (sel_level_ctrl) begin
			read_byte = next_level_byte;
		end else if (sel_power_stat) begin
			read_byte = next_power_byte;
		end
	end

	// read data is captured at setup; status is at most two cycles old when taken
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PRDATA <= RLO_ZERO_WORD;
		end else if (setup_phase && !PWRITE && addr_mapped) begin
			PRDATA <= {{(RLO_DATA_W-RLO_REG_W){1'b0}}, read_byte};
		end else if (setup_phase) begin
			PRDATA <= RLO_ZERO_WORD;
		end
	end

endmodule : rlo_regs_top
`default_nettype wire

// >>> hw/rlo_pkg.sv
// package for the right line-output mixer register slice
// assumes an apb master with 32-bit data and an analog side that reports live status
package rlo_pkg;

	// register indices, byte address is four times the index
	localparam logic [7:0] RLO_IDX_LEFT_DAC = 8'h59;
	localparam logic [7:0] RLO_IDX_LINE_TWO = 8'h5a;
	localparam logic [7:0] RLO_IDX_GAIN_STAGE = 8'h5b;
	localparam logic [7:0] RLO_IDX_RIGHT_DAC = 8'h5c;
	localparam logic [7:0] RLO_IDX_LEVEL_CTRL = 8'h5d;
	localparam logic [7:0] RLO_IDX_POWER_STAT = 8'h5e;

	// apb address layout
	localparam int RLO_ADDR_W = 10;
	localparam int RLO_DATA_W = 32;
	localparam int RLO_REG_W = 8;
	localparam logic [1:0] RLO_WORD_ALIGN = 2'h0;

	// mixer-input register fields
	localparam int RLO_ROUTE_BIT = 7;
	localparam int RLO_VOL_MSB = 6;
	localparam int RLO_VOL_LSB = 0;
	localparam int RLO_VOL_W = 7;
	localparam logic RLO_ROUTE_RST = 1'h0;
	localparam logic [6:0] RLO_VOL_RST = 7'h00;

	// output level control fields
	localparam int RLO_LEVEL_MSB = 7;
	localparam int RLO_LEVEL_LSB = 4;
	localparam int RLO_LEVEL_W = 4;
	localparam int RLO_UNMUTE_BIT = 3;
	localparam int RLO_LVL_RSV_BIT = 2;
	localparam int RLO_PENDING_BIT = 1;
	localparam int RLO_LINE_PWR_BIT = 0;
	localparam logic [3:0] RLO_LEVEL_RST = 4'h0;
	localparam logic [3:0] RLO_LEVEL_MAX = 4'h9;
	localparam logic RLO_UNMUTE_RST = 1'h0;
	localparam logic RLO_PENDING_RST = 1'h1;
	localparam logic RLO_RSV_VALUE = 1'h0;

	// power status fields
	localparam int RLO_PS_LEFT_DAC_BIT = 7;
	localparam int RLO_PS_RIGHT_DAC_BIT = 6;
	localparam int RLO_PS_RSV_HI_BIT = 5;
	localparam int RLO_PS_LEFT_LINE_BIT = 4;
	localparam int RLO_PS_RIGHT_LINE_BIT = 3;
	localparam int RLO_PS_LEFT_HP_BIT = 2;
	localparam int RLO_PS_RIGHT_HP_BIT = 1;
	localparam int RLO_PS_RSV_LO_BIT = 0;

	localparam logic [31:0] RLO_ZERO_WORD = 32'h0000_0000;
	localparam logic [7:0] RLO_ZERO_BYTE = 8'h00;

	typedef struct packed {
		logic route;
		logic [6:0] vol;
	} rlo_mix_s;

	typedef struct packed {
		logic [3:0] level;
		logic unmute;
	} rlo_out_ctrl_s;

	typedef struct packed {
		logic left_dac;
		logic right_dac;
		logic left_line_output;
		logic right_line_output;
		logic left_headphone_driver;
		logic right_headphone_driver;
	} rlo_power_s;

	typedef enum logic [1:0] {
		RLO_IDLE = 2'b01,
		RLO_ACCESS = 2'b10
	} rlo_apb_e;

endpackage : rlo_pkg

// >>> hw/rlo_mix_input_reg.sv
// one mixer-input register: route enable plus 7-bit volume code
// assumes the parent decodes the write and hands over byte lane zero
`timescale 1ns/1ps
`default_nettype none
module rlo_mix_input_reg
	import rlo_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_byte,
	output rlo_mix_s q
);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q.route <= RLO_ROUTE_RST;
			q.vol <= RLO_VOL_RST;
		end else if (wr_en) begin
			q.route <= wr_byte[RLO_ROUTE_BIT];
			q.vol <= wr_byte[RLO_VOL_MSB:RLO_VOL_LSB];
		end
	end

endmodule : rlo_mix_input_reg
`default_nettype wire

// >>> verification/rlo_regs_top_properties.sv
// concurrent checks for the right line-output register slice
// sees only top-level ports; bound from the bench file
`timescale 1ns/1ps
`default_nettype none
module rlo_regs_top_properties
	import rlo_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [RLO_ADDR_W-1:0] PADDR,
	input wire logic [RLO_DATA_W-1:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [RLO_DATA_W-1:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire rlo_mix_s MIX_LEFT_DAC_PATH,
	input wire rlo_out_ctrl_s RIGHT_LINE_OUTPUT_CTRL,
	input wire logic GAIN_UPDATE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic ok;
	logic wr;
	logic rd;
	logic [7:0] ix;
	assign ix = PADDR[9:2];
	assign ok = PADDR[1:0] == 2'h0 && ix >= 8'h59 && ix <= 8'h5e;
	assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && ok;
	assign rd = PSEL && PENABLE && PREADY && !PWRITE && ok;
	ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
		else $error("no single-cycle ready");
	bad_addr_err_a: assert property (PSEL && !PENABLE && !ok |=> PSLVERR && PRDATA == '0)
		else $error("bad address not refused");
	good_addr_ok_a: assert property (PSEL && !PENABLE && ok |=> !PSLVERR)
		else $error("good address refused");
	upper_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	mix_write_a: assert property (wr && ix == 8'h59 |=> MIX_LEFT_DAC_PATH == $past(PWDATA[7:0]))
		else $error("mix write lost");
	gain_pulse_a: assert property (wr && ix <= 8'h5d |=> GAIN_UPDATE ##1 !GAIN_UPDATE)
		else $error("gain pulse missing");
	gain_cause_a: assert property (GAIN_UPDATE |-> $past(wr && ix <= 8'h5d))
		else $error("gain pulse without write");
	ctrl_hold_a: assert property (!(wr && ix == 8'h5d) |=> $stable(RIGHT_LINE_OUTPUT_CTRL))
		else $error("level control changed");
	level_read_a: assert property (rd && ix == 8'h5d |-> PRDATA[7:3] == RIGHT_LINE_OUTPUT_CTRL
		&& !PRDATA[2])
		else $error("level read wrong");
	power_rsv_a: assert property (rd && ix == 8'h5e |-> !PRDATA[5] && !PRDATA[0])
		else $error("power reserved bit set");
endmodule : rlo_regs_top_properties
`default_nettype wire

// >>> verification/rlo_regs_top_bench.sv
// bench for the right line-output register slice
// drives apb and status inputs itself; bus answers are checked from a queue
`timescale 1ns/1ps
`default_nettype none
module rlo_regs_top_bench import rlo_pkg::*;;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, gain_applied = 0;
	logic [9:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [3:0] pstrb = 0;
	logic pready, pslverr, gain_update, g;
	rlo_power_s power_status = 0;
	rlo_mix_s mix[4];
	rlo_out_ctrl_s ctrl;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [32:0] m;
	logic [7:0] v[4];
	logic [5:0] p;
	int failures = 0, cmp_count = 0, seed = 79, k;
	always #4 clk = ~clk;
	rlo_regs_top rlo_regs_top_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .POWER_STATUS(power_status),
		.GAIN_APPLIED(gain_applied), .MIX_LEFT_DAC_PATH(mix[0]), .MIX_RIGHT_LINE_INPUT_TWO(mix[1]),
		.MIX_RIGHT_INPUT_GAIN_STAGE(mix[2]), .MIX_RIGHT_DAC_PATH(mix[3]),
		.RIGHT_LINE_OUTPUT_CTRL(ctrl), .GAIN_UPDATE(gain_update));
	task automatic summarize();
		if (failures == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] s, input logic [31:0] x, input string n);
		cmp_count++;
		if (s !== x) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", n, x, s);
		end
	endtask : chk
	// called just after a rising edge; leaves one idle edge so no signal is set twice
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [32:0] x);
		int i;
		q.push_back(x);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		pstrb <= s;
		@(posedge clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			failures++;
			summarize();
		end
		psel <= 0;
		penable <= 0;
		@(posedge clk);
		g = gain_update;
	endtask : apb
	// index to byte address; registers sit on word multiples, so the index is scaled by four
	function automatic logic [9:0] ad(input int x);
		return {x[7:0], 2'h0};
	endfunction : ad
	// own note variable so the stimulus process keeps its expected value intact
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			m = q.pop_front();
			chk(pslverr, m[32], "error");
			if (!pwrite) chk(prdata, m[31:0], "read data");
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		for (k = 0; k < 4; k++) apb(0, ad(8'h59 + k), 0, 0, 0);
		apb(0, ad(8'h5d), 0, 0, 33'h0_0000_0002);
		apb(0, ad(8'h5e), 0, 0, 0);
		for (k = 0; k < 4; k++) begin
			v[k] = 8'($random(seed));
			apb(1, ad(8'h59 + k), v[k], 4'h1, 0);
			chk(mix[k], v[k], "mix out");
			chk(g, 1, "gain update");
			apb(0, ad(8'h59 + k), 0, 0, {25'h0, v[k]});
		end
		apb(1, ad(8'h59), ~v[0], 4'h0, 0);
		chk(mix[0], v[0], "strobe off");
		gain_applied <= 1;
		@(posedge clk);
		gain_applied <= 0;
		@(posedge clk);
		apb(0, ad(8'h5d), 0, 0, 0);
		// codes above 9 are reserved, so the sweep stops there
		for (k = 0; k < 10; k++) begin
			apb(1, ad(8'h5d), {k[3:0], k[0], 3'h3}, 4'h1, 0);
			chk(ctrl, {k[3:0], k[0]}, "level ctrl");
			apb(0, ad(8'h5d), 0, 0, {25'h0, k[3:0], k[0], 3'h2});
		end
		for (k = 0; k < 4; k++) begin
			p = 6'($random(seed));
			power_status <= p;
			repeat (2) @(posedge clk);
			e = {25'h0, p[5:4], 1'b0, p[3:0], 1'b0};
			apb(0, ad(8'h5e), 0, 0, e);
			apb(0, ad(8'h5d), 0, 0, {25'h0, 7'h4d, p[2]});
			// reserved bits 5 and 0 are written as zero, the rest tries the read-only bits
			apb(1, ad(8'h5e), 8'hde, 4'h1, 0);
			apb(0, ad(8'h5e), 0, 0, e);
		end
		apb(0, ad(8'h58), 0, 0, 33'h1_0000_0000);
		apb(0, 10'h165, 0, 0, 33'h1_0000_0000);
		apb(1, ad(8'h5f), 8'h55, 4'h1, 33'h1_0000_0000);
		chk(mix[0], v[0], "unmapped write");
		summarize();
	end
endmodule : rlo_regs_top_bench
bind rlo_regs_top rlo_regs_top_properties rlo_regs_top_properties_inst (
	.CLK(CLK),
	.RST_N(RST_N),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PWDATA(PWDATA),
	.PSTRB(PSTRB),
	.PRDATA(PRDATA),
	.PREADY(PREADY),
	.PSLVERR(PSLVERR),
	.MIX_LEFT_DAC_PATH(MIX_LEFT_DAC_PATH),
	.RIGHT_LINE_OUTPUT_CTRL(RIGHT_LINE_OUTPUT_CTRL),
	.GAIN_UPDATE(GAIN_UPDATE)
);
`default_nettype wire
